// ==== shared/spl_regs.svh ====
// register offsets, field positions, reset values and timing counts
// of the port pause and lpi qualifier; included by its bare name.
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH

// ==========================================================
// register byte offsets
`define SPL_MANUAL0_OFS       12'h000
`define SPL_MANUAL1_OFS       12'h004
`define SPL_MANUAL2_OFS       12'h008
`define SPL_MODE_OFS          12'h00C
`define SPL_STATUS_OFS        12'h010

// ==========================================================
// manual control word fields, one word per port
`define SPL_MAN_W             5
`define SPL_MAN_SEL_BIT       0
`define SPL_MAN_BP_BIT        1
`define SPL_MAN_TX_BIT        2
`define SPL_MAN_RX_BIT        3
`define SPL_MAN_LPI_BIT       4
`define SPL_MANUAL_RESET      5'h00

// ==========================================================
// port mode word fields and status word fields
`define SPL_MODE0_LSB         0
`define SPL_MODE1_LSB         4
`define SPL_MODE_RESET        8'h01
`define SPL_STAT_RX_LSB       0
`define SPL_STAT_TX_LSB       4
`define SPL_STAT_EEE_LSB      8
`define SPL_STAT_STABLE_LSB   12

// ==========================================================
// link stability time and its cycle count
`define SPL_STABLE_MS         1000
`define SPL_CLK_KHZ           10000
`define SPL_STABLE_CYCLES     (`SPL_STABLE_MS * `SPL_CLK_KHZ)

`endif

// ==== shared/spl_pkg.sv ====
// types shared by the port pause and lpi qualifier modules.
// assumes the register header supplies the register constants; the mode codes are defined here.
`default_nettype none
package spl_pkg;

  // ==========================================================
  // port interface modes
  typedef enum logic [2:0] {
    spl_mode_int_phy  = 3'h0,
    spl_mode_mii_mac  = 3'h1,
    spl_mode_mii_phy  = 3'h2,
    spl_mode_rmii_mac = 3'h3,
    spl_mode_rmii_phy = 3'h4
  } spl_port_mode_type;

  // ==========================================================
  // whole state of the top module
  typedef struct packed {
    logic [2:0][4:0] manual;
    logic [2:0]      mode0;
    logic [2:0]      mode1;
    logic [2:0]      rx_fc;
    logic [2:0]      tx_fc;
    logic [2:0]      permit;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } spl_top_state_type;

endpackage
`default_nettype wire

// ==== verilog/spl_pause_resolve.sv ====
// pause enable resolution for one switch port, purely combinational.
// assumes local/partner roles are already swapped for a virtual phy.
`default_nettype none
`timescale 1ns/10ps
module spl_pause_resolve (
  input  wire logic manual_pause_select,
  input  wire logic backpressure_enable,
  input  wire logic manual_tx_pause_enable,
  input  wire logic manual_rx_pause_enable,
  input  wire logic an_enable,
  input  wire logic an_complete,
  input  wire logic lp_an_able,
  input  wire logic full_duplex,
  input  wire logic local_sym,
  input  wire logic local_asym,
  input  wire logic partner_sym,
  input  wire logic partner_asym,
  output logic      rx_fc,
  output logic      tx_fc
);

  // ==========================================================
  // priority: manual, negotiating, parallel detect, half, full
  always_comb begin
    rx_fc = 1'b0;
    tx_fc = 1'b0;
    if (manual_pause_select || !an_enable) begin
      rx_fc = full_duplex ? manual_rx_pause_enable : 1'b0;
      tx_fc = full_duplex ? manual_tx_pause_enable : backpressure_enable;
    end else if (!an_complete) begin
      rx_fc = 1'b0;
      tx_fc = 1'b0;
    end else if (!lp_an_able || !full_duplex) begin
      tx_fc = backpressure_enable;
    end else if (local_sym && partner_sym) begin
      rx_fc = 1'b1;
      tx_fc = 1'b1;
    end else if (!local_sym && local_asym && partner_sym && partner_asym) begin
      tx_fc = 1'b1;
    end else if (local_sym && local_asym && !partner_sym && partner_asym) begin
      rx_fc = 1'b1;
    end else begin
      rx_fc = 1'b0;
      tx_fc = 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/spl_link_timer.sv ====
// link stability timer: flags a link that stayed up for a full period.
// assumes link_up is synchronous to clk.
`default_nettype none
`timescale 1ns/10ps
module spl_link_timer #(
  parameter int STABLE_CYCLES = 10
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic link_up,
  output logic      stable
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(STABLE_CYCLES);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          stable;
  } spl_timer_state_type;

  spl_timer_state_type state;
  spl_timer_state_type next_state;

  // ==========================================================
  // restart on link loss
  always_comb begin
    next_state = state;
    if (!link_up) begin
      next_state.count  = '0;
      next_state.stable = 1'b0;
    end else if (state.count != LIMIT) begin
      next_state.count  = state.count + CW'(1);
      next_state.stable = (state.count + CW'(1)) == LIMIT;
    end
  end

  // register the copy; clock enable freezes the count
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign stable = state.stable;

endmodule
`default_nettype wire

// ==== verilog/spl_port_qualifier.sv ====
// flow control and lpi permit qualifier for the three switch ports,
// with its control and status words on an apb slave.
// assumes phy status inputs are driven by logic on the same clock.
//
// Notes on behaviour
// - manual or no negotiation uses manual bits
// - negotiation pending forces both enables off
// - no partner negotiation means half, backpressure
// - negotiated half ignores partner, uses backpressure
// - both symmetric pause enables both directions
// - local asym only, partner both: transmit
// - local both, partner asym only: receive
// - other full duplex combinations disable both
// - virtual phy pause bits used role swapped
// - every port gets its own lpi permit
// - lpi needs mode, 100 Mbps, full, agreement; port 0 checks only mode and virtual duplex
// - lpi needs link up one second; only ports on a physical phy wait for it
// - port 0 lpi only in mii mac
// - port 1 internal uses first phy status
// - port 1 mii mac uses virtual duplex only
// - port 2 uses second phy status
// - port 1 flow source follows its mode
// - manual bits never touch phy advertisements
//
// Implementation choices: the placing of the registers and the APB register port.
`default_nettype none
`timescale 1ns/10ps
`include "spl_regs.svh"
module spl_port_qualifier
  import spl_pkg::*;
#(
  parameter int ADDR_W        = 12,
  parameter int STABLE_CYCLES = `SPL_STABLE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // first physical phy
  input  wire logic              phya_an_enable,
  input  wire logic              phya_an_complete,
  input  wire logic              phya_lp_an_able,
  input  wire logic              phya_full_duplex,
  input  wire logic              phya_speed_100,
  input  wire logic              phya_link_up,
  input  wire logic              phya_eee_100_agreed,
  input  wire logic              phya_adv_sym_pause,
  input  wire logic              phya_adv_asym_pause,
  input  wire logic              phya_lp_sym_pause,
  input  wire logic              phya_lp_asym_pause,
  // second physical phy
  input  wire logic              phyb_an_enable,
  input  wire logic              phyb_an_complete,
  input  wire logic              phyb_lp_an_able,
  input  wire logic              phyb_full_duplex,
  input  wire logic              phyb_speed_100,
  input  wire logic              phyb_link_up,
  input  wire logic              phyb_eee_100_agreed,
  input  wire logic              phyb_adv_sym_pause,
  input  wire logic              phyb_adv_asym_pause,
  input  wire logic              phyb_lp_sym_pause,
  input  wire logic              phyb_lp_asym_pause,
  // virtual phy of port 0
  input  wire logic              vphy0_an_enable,
  input  wire logic              vphy0_an_complete,
  input  wire logic              vphy0_lp_an_able,
  input  wire logic              vphy0_full_duplex,
  input  wire logic              vphy0_adv_sym_pause,
  input  wire logic              vphy0_adv_asym_pause,
  input  wire logic              vphy0_lp_sym_pause,
  input  wire logic              vphy0_lp_asym_pause,
  // virtual phy of port 1
  input  wire logic              vphy1_an_enable,
  input  wire logic              vphy1_an_complete,
  input  wire logic              vphy1_lp_an_able,
  input  wire logic              vphy1_full_duplex,
  input  wire logic              vphy1_adv_sym_pause,
  input  wire logic              vphy1_adv_asym_pause,
  input  wire logic              vphy1_lp_sym_pause,
  input  wire logic              vphy1_lp_asym_pause,
  // per-port results, bit n belongs to port n
  output logic      [2:0]        rx_fc_enable,
  output logic      [2:0]        tx_fc_enable,
  output logic      [2:0]        eee_permit,
  output logic      [2:0]        lpi_feature_enable
);

  // ==========================================================
  // register select decode, one-hot
  localparam int SEL_MAN0   = 0;
  localparam int SEL_MAN1   = 1;
  localparam int SEL_MAN2   = 2;
  localparam int SEL_MODE   = 3;
  localparam int SEL_STATUS = 4;
  localparam int SEL_NONE   = 5;

  // used for both the read path and the write path
  function automatic logic [5:0] spl_decode(input logic [ADDR_W-1:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    unique case (addr)
      ADDR_W'(`SPL_MANUAL0_OFS): sel[SEL_MAN0]   = 1'b1;
      ADDR_W'(`SPL_MANUAL1_OFS): sel[SEL_MAN1]   = 1'b1;
      ADDR_W'(`SPL_MANUAL2_OFS): sel[SEL_MAN2]   = 1'b1;
      ADDR_W'(`SPL_MODE_OFS):    sel[SEL_MODE]   = 1'b1;
      ADDR_W'(`SPL_STATUS_OFS):  sel[SEL_STATUS] = 1'b1;
      default:                   sel[SEL_NONE]   = 1'b1;
    endcase
    return sel;
  endfunction

  spl_top_state_type state;
  spl_top_state_type next_state;

  // ==========================================================
  // per-port pause sources
  logic [2:0] src_an_enable;
  logic [2:0] src_an_complete;
  logic [2:0] src_lp_an_able;
  logic [2:0] src_full_duplex;
  logic [2:0] src_local_sym;
  logic [2:0] src_local_asym;
  logic [2:0] src_partner_sym;
  logic [2:0] src_partner_asym;
  logic [2:0] res_rx;
  logic [2:0] res_tx;
  logic       port1_internal;

  assign port1_internal = state.mode1 == spl_mode_int_phy;

  // virtual phys present their own advertisement as the partner's, so
  // the roles are crossed here before resolution
  always_comb begin
    src_an_enable[0]    = vphy0_an_enable;
    src_an_complete[0]  = vphy0_an_complete;
    src_lp_an_able[0]   = vphy0_lp_an_able;
    src_full_duplex[0]  = vphy0_full_duplex;
    src_local_sym[0]    = vphy0_lp_sym_pause;
    src_local_asym[0]   = vphy0_lp_asym_pause;
    src_partner_sym[0]  = vphy0_adv_sym_pause;
    src_partner_asym[0] = vphy0_adv_asym_pause;
    if (port1_internal) begin
      src_an_enable[1]    = phya_an_enable;
      src_an_complete[1]  = phya_an_complete;
      src_lp_an_able[1]   = phya_lp_an_able;
      src_full_duplex[1]  = phya_full_duplex;
      src_local_sym[1]    = phya_adv_sym_pause;
      src_local_asym[1]   = phya_adv_asym_pause;
      src_partner_sym[1]  = phya_lp_sym_pause;
      src_partner_asym[1] = phya_lp_asym_pause;
    end else begin
      src_an_enable[1]    = vphy1_an_enable;
      src_an_complete[1]  = vphy1_an_complete;
      src_lp_an_able[1]   = vphy1_lp_an_able;
      src_full_duplex[1]  = vphy1_full_duplex;
      src_local_sym[1]    = vphy1_lp_sym_pause;
      src_local_asym[1]   = vphy1_lp_asym_pause;
      src_partner_sym[1]  = vphy1_adv_sym_pause;
      src_partner_asym[1] = vphy1_adv_asym_pause;
    end
    src_an_enable[2]    = phyb_an_enable;
    src_an_complete[2]  = phyb_an_complete;
    src_lp_an_able[2]   = phyb_lp_an_able;
    src_full_duplex[2]  = phyb_full_duplex;
    src_local_sym[2]    = phyb_adv_sym_pause;
    src_local_asym[2]   = phyb_adv_asym_pause;
    src_partner_sym[2]  = phyb_lp_sym_pause;
    src_partner_asym[2] = phyb_lp_asym_pause;
  end

  // ==========================================================
  // one resolver per port
  // manual pause bits go only into the resolver; this block has no path
  // back to the phy advertisement registers
  for (genvar g = 0; g < 3; g++) begin : g_resolve
    spl_pause_resolve u_resolve (
      .manual_pause_select    (state.manual[g][`SPL_MAN_SEL_BIT]),
      .backpressure_enable    (state.manual[g][`SPL_MAN_BP_BIT]),
      .manual_tx_pause_enable (state.manual[g][`SPL_MAN_TX_BIT]),
      .manual_rx_pause_enable (state.manual[g][`SPL_MAN_RX_BIT]),
      .an_enable              (src_an_enable[g]),
      .an_complete            (src_an_complete[g]),
      .lp_an_able             (src_lp_an_able[g]),
      .full_duplex            (src_full_duplex[g]),
      .local_sym              (src_local_sym[g]),
      .local_asym             (src_local_asym[g]),
      .partner_sym            (src_partner_sym[g]),
      .partner_asym           (src_partner_asym[g]),
      .rx_fc                  (res_rx[g]),
      .tx_fc                  (res_tx[g])
    );
  end

  // ==========================================================
  // link stability timers for the two physical phys
  logic [1:0] phy_link;
  logic [1:0] phy_stable;

  assign phy_link = {phyb_link_up, phya_link_up};

  for (genvar h = 0; h < 2; h++) begin : g_timer
    spl_link_timer #(
      .STABLE_CYCLES (STABLE_CYCLES)
    ) u_timer (
      .clk     (clk),
      .srst    (srst),
      .ce      (ce),
      .link_up (phy_link[h]),
      .stable  (phy_stable[h])
    );
  end

  // ==========================================================
  // lpi permit qualification
  // the live link level is anded in as well, so the permit leaves on
  // the edge after link loss rather than waiting for the timer flop
  logic [2:0] eee_ok;
  logic       phya_eee_ok;
  logic       phyb_eee_ok;

  assign phya_eee_ok = phya_speed_100 && phya_full_duplex && phya_eee_100_agreed
                       && phya_link_up && phy_stable[0];
  assign phyb_eee_ok = phyb_speed_100 && phyb_full_duplex && phyb_eee_100_agreed
                       && phyb_link_up && phy_stable[1];

  always_comb begin
    eee_ok[0] = (state.mode0 == spl_mode_mii_mac) && vphy0_full_duplex;
    unique case (state.mode1)
      spl_mode_int_phy: eee_ok[1] = phya_eee_ok;
      spl_mode_mii_mac: eee_ok[1] = vphy1_full_duplex;
      default:          eee_ok[1] = 1'b0;
    endcase
    eee_ok[2] = phyb_eee_ok;
  end

  // ==========================================================
  // apb read data assembly
  logic [5:0]  rd_sel;
  logic [5:0]  wr_sel;
  logic [31:0] status_word;
  logic [31:0] read_word;

  assign rd_sel = spl_decode(paddr);
  assign wr_sel = rd_sel;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SPL_STAT_RX_LSB +: 3]     = state.rx_fc;
    status_word[`SPL_STAT_TX_LSB +: 3]     = state.tx_fc;
    status_word[`SPL_STAT_EEE_LSB +: 3]    = state.permit;
    status_word[`SPL_STAT_STABLE_LSB +: 2] = phy_stable;
  end

  // unmapped addresses read zero and raise pslverr
  always_comb begin
    read_word = 32'h0000_0000;
    if (rd_sel[SEL_MAN0]) begin
      read_word[`SPL_MAN_W-1:0] = state.manual[0];
    end
    if (rd_sel[SEL_MAN1]) begin
      read_word[`SPL_MAN_W-1:0] = state.manual[1];
    end
    if (rd_sel[SEL_MAN2]) begin
      read_word[`SPL_MAN_W-1:0] = state.manual[2];
    end
    if (rd_sel[SEL_MODE]) begin
      read_word[`SPL_MODE0_LSB +: 3] = state.mode0;
      read_word[`SPL_MODE1_LSB +: 3] = state.mode1;
    end
    if (rd_sel[SEL_STATUS]) begin
      read_word = status_word;
    end
  end

  // ==========================================================
  // next state: bus slave, register writes, registered results
  // pready is raised in the setup cycle so every transfer completes
  // in its first access cycle; no wait states are ever inserted
  logic setup_phase;
  logic write_done;

  assign setup_phase = psel && !penable && !state.pready;
  assign write_done  = psel && penable && pwrite && state.pready;

  always_comb begin
    next_state         = state;
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;
    if (setup_phase) begin
      next_state.pready  = 1'b1;
      next_state.pslverr = rd_sel[SEL_NONE];
      if (!pwrite) begin
        next_state.prdata = read_word;
      end
    end
    if (write_done) begin
      for (int p = 0; p < 3; p++) begin
        if (wr_sel[p]) begin
          next_state.manual[p] = pwdata[`SPL_MAN_W-1:0];
        end
      end
      if (wr_sel[SEL_MODE]) begin
        next_state.mode0 = pwdata[`SPL_MODE0_LSB +: 3];
        next_state.mode1 = pwdata[`SPL_MODE1_LSB +: 3];
      end
    end
    next_state.rx_fc  = res_rx;
    next_state.tx_fc  = res_tx;
    next_state.permit = eee_ok;
  end

  // ==========================================================
  // state register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (srst) begin
      state        <= '0;
      state.manual <= {3{`SPL_MANUAL_RESET}};
      state.mode0  <= 3'(`SPL_MODE_RESET >> `SPL_MODE0_LSB);
      state.mode1  <= 3'(`SPL_MODE_RESET >> `SPL_MODE1_LSB);
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs straight from the state flops
  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;

  assign rx_fc_enable = state.rx_fc;
  assign tx_fc_enable = state.tx_fc;
  assign eee_permit   = state.permit;

  // the enable bit is not folded into the permit; the mac ands them
  for (genvar k = 0; k < 3; k++) begin : g_lpi
    assign lpi_feature_enable[k] = state.manual[k][`SPL_MAN_LPI_BIT];
  end

endmodule
`default_nettype wire

// ==== verification/spl_port_qualifier_props.sv ====
// checker of the port qualifier: port 2 pause and lpi relations.
// bound into the top module; sees only its ports.
`default_nettype none
`timescale 1ns/10ps
`include "spl_regs.svh"
module spl_port_qualifier_props #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              phyb_an_enable,
  input wire logic              phyb_an_complete,
  input wire logic              phyb_lp_an_able,
  input wire logic              phyb_full_duplex,
  input wire logic              phyb_speed_100,
  input wire logic              phyb_link_up,
  input wire logic              phyb_eee_100_agreed,
  input wire logic              phyb_adv_sym_pause,
  input wire logic              phyb_adv_asym_pause,
  input wire logic              phyb_lp_sym_pause,
  input wire logic              phyb_lp_asym_pause,
  input wire logic [2:0]        rx_fc_enable,
  input wire logic [2:0]        tx_fc_enable,
  input wire logic [2:0]        eee_permit
);
  logic [4:0] man2;
  logic       quiet;
  logic       auto_b;
  logic       full_b;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // shadow of the port 2 manual word
  always_ff @(posedge clk) begin
    if (srst) begin
      man2 <= `SPL_MANUAL_RESET;
    end else if (ce && psel && penable && pready && pwrite && paddr == `SPL_MANUAL2_OFS) begin
      man2 <= pwdata[4:0];
    end
  end
  assign quiet  = ce && !(psel && penable && pready);
  assign auto_b = quiet && !man2[0] && phyb_an_enable && phyb_an_complete;
  assign full_b = auto_b && phyb_lp_an_able && phyb_full_duplex;
  // ==========================================================
  // port 2 results against their causes
  AST_MANUAL_FULL: assert property (
    quiet && (man2[0] || !phyb_an_enable) && phyb_full_duplex
    |=> rx_fc_enable[2] == man2[3] && tx_fc_enable[2] == man2[2]) else $error("manual ignored");
  AST_PENDING: assert property (
    quiet && !man2[0] && phyb_an_enable && !phyb_an_complete |=> !rx_fc_enable[2] && !tx_fc_enable[2])
    else $error("pause while pending");
  AST_PARALLEL: assert property (
    auto_b && !phyb_lp_an_able |=> !rx_fc_enable[2] && tx_fc_enable[2] == man2[1])
    else $error("parallel detect not half");
  AST_NEG_HALF: assert property (
    auto_b && phyb_lp_an_able && !phyb_full_duplex |=> !rx_fc_enable[2] && tx_fc_enable[2] == man2[1])
    else $error("half not backpressure");
  AST_SYM: assert property (
    full_b && phyb_adv_sym_pause && phyb_lp_sym_pause |=> rx_fc_enable[2] && tx_fc_enable[2])
    else $error("symmetric pause not both");
  AST_ASYM_TX: assert property (
    full_b && !phyb_adv_sym_pause && phyb_adv_asym_pause && phyb_lp_sym_pause && phyb_lp_asym_pause
    |=> !rx_fc_enable[2] && tx_fc_enable[2]) else $error("tx only case wrong");
  AST_ASYM_RX: assert property (
    full_b && phyb_adv_sym_pause && phyb_adv_asym_pause && !phyb_lp_sym_pause && phyb_lp_asym_pause
    |=> rx_fc_enable[2] && !tx_fc_enable[2]) else $error("rx only case wrong");
  AST_LINK_LOSS: assert property (
    ce && !phyb_link_up |=> !eee_permit[2]) else $error("permit kept after link loss");
  AST_QUALIFY: assert property (
    eee_permit[2] |-> $past(phyb_speed_100 && phyb_full_duplex && phyb_eee_100_agreed))
    else $error("unqualified permit");
endmodule
bind spl_port_qualifier spl_port_qualifier_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// ==== verification/spl_phy_model.sv ====
// partner model: status word of one physical or virtual phy.
// assumes the bench sets the word; bits an_en down to lp_asym.
`default_nettype none
`timescale 1ns/10ps
module spl_phy_model (
  input  wire logic        clk,
  input  wire logic [10:0] cfg,
  output logic      [10:0] status
);
  // ==========================================================
  // status moves only on the clock
  always_ff @(posedge clk) begin
    status <= cfg;
  end
endmodule
`default_nettype wire

// ==== verification/switch_port_pause_lpi_enable_tb.sv ====
// bench of the port qualifier: pause case table, then modes and lpi.
// assumes a 10 MHz clock and phy words from the partner models.
`default_nettype none
`timescale 1ns/10ps
`include "spl_regs.svh"
module switch_port_pause_lpi_enable_tb;
  logic        clk, srst, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  rx_fc_enable, tx_fc_enable, eee_permit, lpi_feature_enable;
  logic [10:0] cfg_a, cfg_b, cfg_v0, cfg_v1, st_a, st_b, st_v0, st_v1;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, i, m;
  // manual {rx,tx,bp,sel}, phy {an_en,done,lp_able,full,lsym,lasym,psym,pasym}, {rx,tx}
  logic [13:0] rows [14] = '{14'h0F81, 14'h2042, 14'h0A7C, 14'h0B7D, 14'h0BBD, 14'h03EB, 14'h03DD,
    14'h03F6, 14'h03CC, 14'h03D0, 14'h03D8, 14'h03E0, 14'h03F0, 14'h07E8};
  spl_phy_model u_phya (.clk, .cfg(cfg_a), .status(st_a));
  spl_phy_model u_phyb (.clk, .cfg(cfg_b), .status(st_b));
  spl_phy_model u_vphy0 (.clk, .cfg(cfg_v0), .status(st_v0));
  spl_phy_model u_vphy1 (.clk, .cfg(cfg_v1), .status(st_v1));
  // short stability count
  spl_port_qualifier #(.STABLE_CYCLES(20)) dut (
    .clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .phya_an_enable(st_a[10]), .phya_an_complete(st_a[9]), .phya_lp_an_able(st_a[8]),
    .phya_full_duplex(st_a[7]), .phya_speed_100(st_a[6]), .phya_link_up(st_a[5]),
    .phya_eee_100_agreed(st_a[4]), .phya_adv_sym_pause(st_a[3]), .phya_adv_asym_pause(st_a[2]),
    .phya_lp_sym_pause(st_a[1]), .phya_lp_asym_pause(st_a[0]),
    .phyb_an_enable(st_b[10]), .phyb_an_complete(st_b[9]), .phyb_lp_an_able(st_b[8]),
    .phyb_full_duplex(st_b[7]), .phyb_speed_100(st_b[6]), .phyb_link_up(st_b[5]),
    .phyb_eee_100_agreed(st_b[4]), .phyb_adv_sym_pause(st_b[3]), .phyb_adv_asym_pause(st_b[2]),
    .phyb_lp_sym_pause(st_b[1]), .phyb_lp_asym_pause(st_b[0]),
    .vphy0_an_enable(st_v0[10]), .vphy0_an_complete(st_v0[9]), .vphy0_lp_an_able(st_v0[8]),
    .vphy0_full_duplex(st_v0[7]), .vphy0_adv_sym_pause(st_v0[3]), .vphy0_adv_asym_pause(st_v0[2]),
    .vphy0_lp_sym_pause(st_v0[1]), .vphy0_lp_asym_pause(st_v0[0]),
    .vphy1_an_enable(st_v1[10]), .vphy1_an_complete(st_v1[9]), .vphy1_lp_an_able(st_v1[8]),
    .vphy1_full_duplex(st_v1[7]), .vphy1_adv_sym_pause(st_v1[3]), .vphy1_adv_asym_pause(st_v1[2]),
    .vphy1_lp_sym_pause(st_v1[1]), .vphy1_lp_asym_pause(st_v1[0]),
    .rx_fc_enable, .tx_fc_enable, .eee_permit, .lpi_feature_enable
  );
  // ==========================================================
  // clock, hang guard and verdict
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {clk, srst, ce} = 3'h3;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0000_0000_0000;
    {cfg_a, cfg_b, cfg_v0, cfg_v1} = 44'h000_0000_0000;
    wt(4);
    srst <= 1'h0;
    apb(1'h0, `SPL_MANUAL2_OFS);
    chk("manual2_reset", 1'h0, q);
    apb(1'h0, `SPL_MODE_OFS);
    chk("mode_reset", 1'h1, q);
    apb(1'h0, 12'h020);
    chk("unmapped_err", 1'h1, e);
    chk("unmapped_data", 1'h0, q);
    // pause resolution table on port 2
    for (i = 0; i < 14; i++) begin
      apb(1'h1, `SPL_MANUAL2_OFS, {28'h000_0000, rows[i][13:10]});
      cfg_b <= {rows[i][9:6], 3'h0, rows[i][5:2]};
      wt(3);
      chk("rx2", rows[i][1], rx_fc_enable[2]);
      chk("tx2", rows[i][0], tx_fc_enable[2]);
    end
    apb(1'h1, `SPL_MANUAL2_OFS, 32'h0000_0010);
    wt(1);
    chk("lpi_enable", 3'h4, lpi_feature_enable);
    // vphy0 adv both, partner asym: swapped gives tx only
    cfg_v0 <= 11'h78D;
    cfg_a <= 11'h7FA;
    cfg_v1 <= 11'h780;
    cfg_b <= 11'h7F0;
    wt(12);
    chk("p0_pause", 2'h1, {rx_fc_enable[0], tx_fc_enable[0]});
    chk("permit2_early", 1'h0, eee_permit[2]);
    wt(20);
    chk("permit2", 1'h1, eee_permit[2]);
    // every mode code on ports 0 and 1
    for (m = 0; m < 5; m++) begin
      apb(1'h1, `SPL_MODE_OFS, {25'h000_0000, m[2:0], 1'h0, m[2:0]});
      wt(3);
      chk("permit0", m == 1, eee_permit[0]);
      chk("permit1", m <= 1, eee_permit[1]);
      chk("rx1", m == 0, rx_fc_enable[1]);
    end
    // link drop restarts the stability wait
    cfg_b <= 11'h7D0;
    wt(3);
    chk("permit2_loss", 1'h0, eee_permit[2]);
    cfg_b <= 11'h7F0;
    wt(12);
    chk("permit2_restart", 1'h0, eee_permit[2]);
    wt(20);
    chk("permit2_again", 1'h1, eee_permit[2]);
    cfg_b <= 11'h7E0;
    wt(3);
    chk("permit2_no_eee", 1'h0, eee_permit[2]);
    // status is read only
    apb(1'h1, `SPL_STATUS_OFS, 32'hFFFF_FFFF);
    apb(1'h0, `SPL_STATUS_OFS);
    chk("status", 32'h0000_3010, q);
    ce <= 1'h0;
    cfg_b <= 11'h7F0;
    wt(3);
    chk("permit2_frozen", 1'h0, eee_permit[2]);
    results();
  end
endmodule
`default_nettype wire
